/* File: mmicr_regs.sv */
// What this block does
// - ack or poll read sets in-service flag
// - in-service blocks lower priority requests
// - in-service: timer, two dma, four pins
// - in-service cleared by eoi or write
// - request timer bit ors three timers
// - pin request bits live, unwritable, edge aware
// - internal requests cleared on acknowledge, lowest timer bit only
// - dma request bits writable, rest read-only
// - mask register shares control inhibit bits
// - threshold blocks numerically greater priorities
// - threshold resets to seven
// - dma stop: nmi sets, return_from_interrupt clears
// - status holds three timer request bits
// - control word priority and inhibit fields
// - trigger select: level or rising edge
// - pins a, b carry cascade and nesting bits
// - cascade or nesting disables pins c, d
// - eoi write-only, specific or non-specific
// - poll read acknowledges, status read pure
// - poll words give presence and vector
// - presence bit 15, vector bits 4..0
// - non-specific eoi clears best in-service
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module mmicr_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire mmicr_pkg::mmicr_bus_type regBus,
    output logic [15:0] regRdData,
    input wire logic [2:0] timerEvent,
    input wire logic [1:0] dmaEvent,
    input wire logic [3:0] ext_pin_flags,
    input wire logic nmiEvent,
    input wire logic return_from_interrupt,
    input wire logic intAck,
    output logic cpuIrq,
    output logic [4:0] ackVector,
    output logic dmaHalt
);
    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rstPipe;    // two-stage release of the reset
    logic rstn;             // synchronised reset for the rest
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstn = rstPipe[1];

    // ****************************************************************
    // state
    // ****************************************************************
    logic [20:0] prioFlat;      // priority fields, three bits a source
    logic [6:0] inhibit;        // shared mask / inhibit storage
    logic [6:0] inServ;         // source index order
    logic [3:0] trigSel;        // per pin: 1 level, 0 edge
    logic [1:0] cascSel;        // pins a, b
    logic [1:0] nestEn;         // pins a, b
    logic [2:0] threshold;
    logic [1:0] dmaReq;
    logic [2:0] per_timer_request;
    logic [3:0] armed;          // edge mode: pin seen low since ack

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // best candidate: lowest priority number, ties to lowest index
    function automatic logic [3:0] pickBest(input logic [6:0] cand,
                                            input logic [20:0] pr);
        logic found;
        logic [2:0] idx;
        logic [2:0] best;
        found = 1'b0;
        idx = 3'h0;
        best = 3'h7;
        for (int i = mmicr_pkg::NSRC - 1; i >= 0; i--) begin
            if (cand[i] && (!found || pr[i*3 +: 3] <= best)) begin
                found = 1'b1;
                idx = 3'(i);
                best = pr[i*3 +: 3];
            end
        end
        return {found, idx};
    endfunction : pickBest

    // vector type back to source index
    function automatic logic [3:0] vecToIdx(input logic [4:0] v);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 0; i < mmicr_pkg::NSRC; i++) begin
            if (v == mmicr_pkg::VEC_TYPE[i]) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : vecToIdx

    // source order to register layout: tmr 0, dma 2..3, pins 4..7
    function automatic logic [15:0] toWord(input logic [6:0] v);
        return {8'h00, v[6:3], v[2:1], 1'b0, v[0]};
    endfunction : toWord

    function automatic logic [6:0] fromWord(input logic [15:0] w);
        return {w[7:4], w[3:2], w[0]};
    endfunction : fromWord

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic wrMask, wrThresh, wrInsrv, wrReq, wrStat, wrEoi;
    logic rdPoll;
    logic [6:0] wrCtrl;     // one bit per control word
    assign wrMask = regBus.wr && regBus.addr == mmicr_pkg::OFF_MASK;
    assign wrThresh = regBus.wr && regBus.addr == mmicr_pkg::OFF_THRESH;
    assign wrInsrv = regBus.wr && regBus.addr == mmicr_pkg::OFF_INSRV;
    assign wrReq = regBus.wr && regBus.addr == mmicr_pkg::OFF_REQ;
    assign wrStat = regBus.wr && regBus.addr == mmicr_pkg::OFF_STAT;
    assign wrEoi = regBus.wr && regBus.addr == mmicr_pkg::OFF_EOI;
    assign rdPoll = regBus.rd && regBus.addr == mmicr_pkg::OFF_POLL;
    for (genvar g = 0; g < mmicr_pkg::NSRC; g++) begin : gDec
        assign wrCtrl[g] = regBus.wr &&
                           regBus.addr == mmicr_pkg::CTRL_OFF[g];
    end

    // ****************************************************************
    // requests and arbitration
    // ****************************************************************
    logic extLocked;        // pins c, d taken by cascade / nesting
    logic [6:0] req;        // raw requests, source order
    logic [6:0] eligible;
    logic [3:0] win;        // {found, index}
    logic winFound;
    logic [2:0] winIdx;
    logic [3:0] bestIs;     // best in-service source
    logic ackNow;           // acknowledge cycle or poll read
    logic [6:0] ackOne;     // one-hot acknowledged source
    assign extLocked = |cascSel || |nestEn;
    assign req[0] = |per_timer_request;
    assign req[2:1] = dmaReq;
    for (genvar p = 0; p < 4; p++) begin : gPin
        // live from the pin; edge mode needs a low first
        assign req[mmicr_pkg::EXT0 + p] = ext_pin_flags[p] &&
                                          (trigSel[p] || armed[p]);
    end
    for (genvar s = 0; s < mmicr_pkg::NSRC; s++) begin : gElig
        logic lowerThanIs;  // an in-service source outranks this one
        logic ownBusy;      // own service routine still running
        always_comb begin
            lowerThanIs = 1'b0;
            for (int j = 0; j < mmicr_pkg::NSRC; j++) begin
                if (inServ[j] &&
                    prioFlat[s*3 +: 3] > prioFlat[j*3 +: 3]) begin
                    lowerThanIs = 1'b1;
                end
            end
        end
        // nesting mode lets a pin re-enter over its own flag
        if (s == mmicr_pkg::EXT0 || s == mmicr_pkg::EXT0 + 1) begin : gN
            assign ownBusy = inServ[s] && !nestEn[s - mmicr_pkg::EXT0];
        end else begin : gP
            assign ownBusy = inServ[s];
        end
        assign eligible[s] = req[s] && !inhibit[s] &&
            prioFlat[s*3 +: 3] <= threshold &&
            !lowerThanIs && !ownBusy &&
            !(extLocked && s >= mmicr_pkg::EXT0 + 2);
    end
    assign win = pickBest(eligible, prioFlat);
    assign winFound = win[3];
    assign winIdx = win[2:0];
    assign bestIs = pickBest(inServ, prioFlat);
    assign ackNow = (intAck || rdPoll) && winFound;
    assign ackOne = ackNow ? 7'(7'h01 << winIdx) : 7'h00;

    // ****************************************************************
    // control words and shared inhibit bits
    // ****************************************************************
    // priority, trigger, cascade and nesting fields
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prioFlat <= {7{mmicr_pkg::PRIO_RESET}};
            trigSel <= 4'h0;
            cascSel <= 2'h0;
            nestEn <= 2'h0;
        end else begin
            for (int i = 0; i < mmicr_pkg::NSRC; i++) begin
                if (wrCtrl[i]) begin
                    prioFlat[i*3 +: 3] <= regBus.data[2:0];
                    if (i >= mmicr_pkg::EXT0) begin
                        trigSel[i - mmicr_pkg::EXT0] <=
                            regBus.data[mmicr_pkg::TRIG_BIT];
                    end
                    // only pins a, b keep the extra bits
                    if (i == mmicr_pkg::EXT0 || i == mmicr_pkg::EXT0 + 1)
                    begin
                        cascSel[i - mmicr_pkg::EXT0] <=
                            regBus.data[mmicr_pkg::CASC_BIT];
                        nestEn[i - mmicr_pkg::EXT0] <=
                            regBus.data[mmicr_pkg::NEST_BIT];
                    end
                end
            end
        end
    end

    // one storage bit serves both views of each mask
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inhibit <= mmicr_pkg::INHIBIT_RESET;
        end else if (wrMask) begin
            inhibit <= fromWord(regBus.data);
        end else begin
            for (int i = 0; i < mmicr_pkg::NSRC; i++) begin
                if (wrCtrl[i]) begin
                    inhibit[i] <= regBus.data[mmicr_pkg::INHIBIT_BIT];
                end
            end
        end
    end

    // threshold code, low three bits only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            threshold <= mmicr_pkg::THRESH_RESET;
        end else if (wrThresh) begin
            threshold <= regBus.data[2:0];
        end
    end

    // ****************************************************************
    // in-service flags
    // ****************************************************************
    // clears first, acknowledge last so a same-cycle set wins
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inServ <= 7'h00;
        end else begin
            logic [6:0] nxt;
            logic [3:0] hit;
            nxt = inServ;
            hit = vecToIdx(regBus.data[4:0]);
            if (wrInsrv) begin
                nxt = fromWord(regBus.data);
            end else if (wrEoi) begin
                if (regBus.data[mmicr_pkg::EOI_TYPE_BIT]) begin
                    if (bestIs[3]) begin
                        nxt[bestIs[2:0]] = 1'b0;
                    end
                end else if (hit[3]) begin
                    nxt[hit[2:0]] = 1'b0;
                end
            end
            inServ <= nxt | ackOne;
        end
    end

    // ****************************************************************
    // internal requests
    // ****************************************************************
    // dma requests: written directly, dropped on acknowledge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dmaReq <= 2'h0;
        end else begin
            logic [1:0] nxt;
            nxt = dmaReq & ~ackOne[2:1];
            if (wrReq) begin
                nxt = regBus.data[mmicr_pkg::DMA0_REQ_BIT +: 2];
            end
            dmaReq <= nxt | dmaEvent;
        end
    end

    // per-timer bits; ack retires only the lowest so others survive
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            per_timer_request <= 3'h0;
        end else begin
            logic [2:0] nxt;
            nxt = per_timer_request;
            if (wrStat) begin
                nxt = regBus.data[2:0];
            end else if (ackOne[0]) begin
                nxt = nxt & (nxt - 3'h1);
            end
            per_timer_request <= nxt | timerEvent;
        end
    end

    // edge arming: a low pin re-arms, an edge-mode ack disarms
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            armed <= 4'hF;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (!ext_pin_flags[p]) begin
                    armed[p] <= 1'b1;
                end else if (ackOne[mmicr_pkg::EXT0 + p] && !trigSel[p]) begin
                    armed[p] <= 1'b0;
                end
            end
        end
    end

    // dma stop: nmi wins over a same-cycle return or write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dmaHalt <= 1'b0;
        end else if (nmiEvent) begin
            dmaHalt <= 1'b1;
        end else if (return_from_interrupt) begin
            dmaHalt <= 1'b0;
        end else if (wrStat) begin
            dmaHalt <= regBus.data[mmicr_pkg::DMA_STOP_BIT];
        end
    end

    // ****************************************************************
    // cpu side and read data
    // ****************************************************************
    // registered request and acknowledged vector
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cpuIrq <= 1'b0;
            ackVector <= 5'h00;
        end else begin
            cpuIrq <= winFound;
            if (intAck && winFound) begin
                ackVector <= mmicr_pkg::VEC_TYPE[winIdx];
            end
        end
    end

    logic [15:0] pollWord;  // same word for both poll views
    logic [15:0] rdMux;
    assign pollWord = winFound ?
        {1'b1, 10'h000, mmicr_pkg::VEC_TYPE[winIdx]} : 16'h0000;
    // read mux; unused bits and the write-only eoi read zero
    always_comb begin
        rdMux = 16'h0000;
        case (regBus.addr)
            mmicr_pkg::OFF_POLL, mmicr_pkg::OFF_PSTAT: rdMux = pollWord;
            mmicr_pkg::OFF_MASK: rdMux = toWord(inhibit);
            mmicr_pkg::OFF_THRESH: rdMux = {13'h0000, threshold};
            mmicr_pkg::OFF_INSRV: rdMux = toWord(inServ);
            mmicr_pkg::OFF_REQ: rdMux = toWord(req);
            mmicr_pkg::OFF_STAT: rdMux = {dmaHalt, 12'h000, per_timer_request};
            default: begin
                for (int i = 0; i < mmicr_pkg::NSRC; i++) begin
                    if (regBus.addr == mmicr_pkg::CTRL_OFF[i]) begin
                        rdMux = {12'h000, inhibit[i], prioFlat[i*3 +: 3]};
                        if (i >= mmicr_pkg::EXT0) begin
                            rdMux[4] = trigSel[i - mmicr_pkg::EXT0];
                        end
                        if (i == mmicr_pkg::EXT0 || i == mmicr_pkg::EXT0 + 1)
                        begin
                            rdMux[5] = cascSel[i - mmicr_pkg::EXT0];
                            rdMux[6] = nestEn[i - mmicr_pkg::EXT0];
                        end
                    end
                end
            end
        endcase
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 16'h0000;
        end else begin
            regRdData <= regBus.rd ? rdMux : 16'h0000;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence seqPollRead;
        rdPoll && winFound;
    endsequence
    sequence seqStatusRead;
        regBus.rd && regBus.addr == mmicr_pkg::OFF_PSTAT && !intAck;
    endsequence
    chk_ack_sets_flag: assert property ((intAck && winFound) |=>
        inServ[$past(winIdx)]) else $error("ack did not set flag");
    chk_poll_sets_flag: assert property (seqPollRead |=>
        inServ[$past(winIdx)] && regRdData[15]) else $error("poll read");
    chk_status_pure: assert property (seqStatusRead |=>
        $stable(inServ)) else $error("status read changed flags");
    chk_win_threshold: assert property (winFound |->
        prioFlat[winIdx*3 +: 3] <= threshold) else $error("threshold");
    chk_irq_follows: assert property (winFound ##1 winFound |->
        cpuIrq) else $error("cpu request missing");
    chk_nmi_stop: assert property (nmiEvent |=> dmaHalt)
        else $error("nmi did not stop dma");
    // a return with no nmi beside it must lower the stop flag
    chk_return_clear: assert property ((return_from_interrupt &&
        !nmiEvent) |=> !dmaHalt) else $error("return kept dma stopped");
    chk_threshold_reset: assert property (@(posedge clk_sys)
        $rose(rstn) |-> threshold == 3'h7) else $error("threshold reset");
    chk_dma_write: assert property ((wrReq && dmaEvent == 2'h0) |=>
        dmaReq == $past(regBus.data[3:2])) else $error("dma write");
    chk_edge_disarm: assert property ((ackOne[3] && !trigSel[0] &&
        ext_pin_flags[0]) ##1 ext_pin_flags[0] |-> !req[3])
        else $error("edge pin requested twice");
endmodule : mmicr_regs
`default_nettype wire

/* File: mmicr_pkg.sv */
// ****************************************************************
// shared constants for the master mode interrupt controller
// ****************************************************************
package mmicr_pkg;
    // register bus request travelling into the controller
    typedef struct packed {
        logic [7:0] addr;   // byte offset of the register
        logic [15:0] data;  // write data
        logic wr;           // one-cycle write strobe
        logic rd;           // one-cycle read strobe
    } mmicr_bus_type;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] OFF_EOI = 8'h22;
    localparam logic [7:0] OFF_POLL = 8'h24;
    localparam logic [7:0] OFF_PSTAT = 8'h26;
    localparam logic [7:0] OFF_MASK = 8'h28;
    localparam logic [7:0] OFF_THRESH = 8'h2A;
    localparam logic [7:0] OFF_INSRV = 8'h2C;
    localparam logic [7:0] OFF_REQ = 8'h2E;
    localparam logic [7:0] OFF_STAT = 8'h30;
    // control words: timer, dma0, dma1, ext pins a..d
    localparam logic [7:0] CTRL_OFF [7] = '{8'h32, 8'h34, 8'h36, 8'h38,
                                           8'h3A, 8'h3C, 8'h3E};

    // ****************************************************************
    // sources, vector types and field positions
    // ****************************************************************
    localparam int NSRC = 7;            // timer, dma0, dma1, four pins
    localparam int EXT0 = 3;            // index of first external pin
    localparam logic [4:0] VEC_TYPE [7] = '{5'h08, 5'h0A, 5'h0B, 5'h0C,
                                           5'h0D, 5'h0E, 5'h0F};
    localparam int PRI_LSB = 0;         // priority field, bits 2..0
    localparam int INHIBIT_BIT = 3;
    localparam int TRIG_BIT = 4;
    localparam int CASC_BIT = 5;
    localparam int NEST_BIT = 6;
    localparam int EOI_TYPE_BIT = 15;   // 1 = non-specific
    localparam int PRESENT_BIT = 15;    // poll words
    localparam int DMA_STOP_BIT = 15;   // status register
    localparam int DMA0_REQ_BIT = 2;    // request register dma bits
    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [2:0] THRESH_RESET = 3'h7;
    localparam logic [2:0] PRIO_RESET = 3'h7;
    localparam logic [6:0] INHIBIT_RESET = 7'h7F;
endpackage : mmicr_pkg

/* File: mmicr_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// far side: external requesters on the four interrupt pins
// ****************************************************************
module mmicr_pin_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] raise,  // one-cycle order to raise a pin
    input wire logic [3:0] drop,   // one-cycle order to release a pin
    output logic [3:0] pins        // active-high request levels
);
    // a pin stays high until the bench drops it after the acknowledge,
    // so an edge-mode request is never lost by an early release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pins <= 4'h0;
        end else begin
            pins <= (pins & ~drop) | raise;
        end
    end
endmodule : mmicr_pin_model
`default_nettype wire

/* File: mmicr_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// self-checking bench for the controller registers
// ****************************************************************
module mmicr_regs_test;
    logic clk_sys;
    logic resetn;
    mmicr_pkg::mmicr_bus_type regBus;
    logic [15:0] regRdData;
    logic [2:0] timerEvent;
    logic [1:0] dmaEvent;
    logic [3:0] pins;
    logic [3:0] raise;
    logic [3:0] drop;
    logic nmiEvent;
    logic rfi;
    logic intAck;
    logic cpuIrq;
    logic dmaHalt;
    logic [4:0] ackVector;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;

    mmicr_regs u_mmicr_regs (.clk_sys(clk_sys), .resetn(resetn),
        .regBus(regBus), .regRdData(regRdData), .timerEvent(timerEvent),
        .dmaEvent(dmaEvent), .ext_pin_flags(pins), .nmiEvent(nmiEvent),
        .return_from_interrupt(rfi), .intAck(intAck), .cpuIrq(cpuIrq),
        .ackVector(ackVector), .dmaHalt(dmaHalt));
    mmicr_pin_model u_mmicr_pin_model (.clk_sys(clk_sys),
        .resetn(resetn), .raise(raise), .drop(drop), .pins(pins));

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    // wait n edges, then step past them so outputs have settled
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wt

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regBus <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        regBus.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        regBus <= '{addr: a, data: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        regBus.rd <= 1'b0;
        #1 cmp("read data", exp, regRdData);
    endtask : rd

    // bits: 6 nmi, 5 return, 4..3 dma, 2..0 timers
    task automatic ev(input logic [6:0] v);
        @(posedge clk_sys);
        {nmiEvent, rfi, dmaEvent, timerEvent} <= v;
        @(posedge clk_sys);
        {nmiEvent, rfi, dmaEvent, timerEvent} <= 7'h00;
    endtask : ev

    task automatic pin(input logic [3:0] r, input logic [3:0] d);
        @(posedge clk_sys);
        raise <= r;
        drop <= d;
        @(posedge clk_sys);
        raise <= 4'h0;
        drop <= 4'h0;
    endtask : pin

    // bounded wait for a request, then one acknowledge pulse
    task automatic ack(input logic [4:0] v);
        for (int i = 0; i < 50 && cpuIrq !== 1'b1; i++) wt(1);
        @(posedge clk_sys);
        intAck <= 1'b1;
        @(posedge clk_sys);
        intAck <= 1'b0;
        #1 cmp("ack vector", v, ackVector);
    endtask : ack

    // hang guard: far above the roughly 150 cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        regBus = '0;
        {nmiEvent, rfi, dmaEvent, timerEvent} = 7'h00;
        intAck = 1'b0;
        raise = 4'h0;
        drop = 4'h0;
        // release on a rising edge, like every other input
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        wt(3);
        rd(mmicr_pkg::OFF_THRESH, 16'h0007);
        rd(mmicr_pkg::OFF_MASK, 16'h00FD);
        rd(mmicr_pkg::CTRL_OFF[0], 16'h000F);
        wr(mmicr_pkg::OFF_MASK, 16'h0000);
        rd(mmicr_pkg::CTRL_OFF[0], 16'h0007);
        wr(mmicr_pkg::CTRL_OFF[1], 16'h0002);
        wr(mmicr_pkg::OFF_REQ, 16'hFFFF);
        rd(mmicr_pkg::OFF_REQ, 16'h000C);
        wr(mmicr_pkg::OFF_REQ, 16'h0000);
        rd(mmicr_pkg::OFF_REQ, 16'h0000);
        // dma0 request, polled without and then with acknowledge
        ev(7'h08);
        rd(mmicr_pkg::OFF_PSTAT, 16'h800A);
        rd(mmicr_pkg::OFF_INSRV, 16'h0000);
        rd(mmicr_pkg::OFF_POLL, 16'h800A);
        rd(mmicr_pkg::OFF_INSRV, 16'h0004);
        rd(mmicr_pkg::OFF_REQ, 16'h0000);
        // lower-priority timer held off by dma0 in service
        ev(7'h02);
        rd(mmicr_pkg::OFF_STAT, 16'h0002);
        rd(mmicr_pkg::OFF_REQ, 16'h0001);
        cmp("cpu request", 1'b0, cpuIrq);
        wr(mmicr_pkg::OFF_EOI, 16'h8000);
        rd(mmicr_pkg::OFF_INSRV, 16'h0000);
        ack(5'h08);
        rd(mmicr_pkg::OFF_INSRV, 16'h0001);
        rd(mmicr_pkg::OFF_STAT, 16'h0000);
        wr(mmicr_pkg::OFF_EOI, 16'h0008);
        rd(mmicr_pkg::OFF_INSRV, 16'h0000);
        // threshold just below and then at the timer's level
        wr(mmicr_pkg::OFF_THRESH, 16'h0004);
        wr(mmicr_pkg::CTRL_OFF[0], 16'h0005);
        ev(7'h01);
        wt(4);
        cmp("cpu request", 1'b0, cpuIrq);
        wr(mmicr_pkg::OFF_THRESH, 16'h0005);
        wt(3);
        cmp("cpu request", 1'b1, cpuIrq);
        ack(5'h08);
        wr(mmicr_pkg::OFF_INSRV, 16'h0000);
        rd(mmicr_pkg::OFF_INSRV, 16'h0000);
        // pin a in edge mode, then level mode
        wr(mmicr_pkg::CTRL_OFF[3], 16'h0001);
        pin(4'h1, 4'h0);
        rd(mmicr_pkg::OFF_REQ, 16'h0010);
        ack(5'h0C);
        rd(mmicr_pkg::OFF_REQ, 16'h0000);
        wr(mmicr_pkg::OFF_INSRV, 16'h0000);
        wr(mmicr_pkg::CTRL_OFF[3], 16'h0011);
        rd(mmicr_pkg::OFF_REQ, 16'h0010);
        pin(4'h0, 4'h1);
        // cascade on pin a silences pin c
        wr(mmicr_pkg::CTRL_OFF[3], 16'h0021);
        rd(mmicr_pkg::CTRL_OFF[3], 16'h0021);
        wr(mmicr_pkg::CTRL_OFF[5], 16'h0000);
        pin(4'h4, 4'h0);
        wt(4);
        cmp("cpu request", 1'b0, cpuIrq);
        // nesting instead of cascade keeps pin c silenced
        wr(mmicr_pkg::CTRL_OFF[3], 16'h0041);
        rd(mmicr_pkg::CTRL_OFF[3], 16'h0041);
        wt(3);
        cmp("cpu request", 1'b0, cpuIrq);
        pin(4'h0, 4'h4);
        // dma stop flag: nmi, return, software
        ev(7'h40);
        wt(1);
        cmp("dma halt", 1'b1, dmaHalt);
        rd(mmicr_pkg::OFF_STAT, 16'h8000);
        ev(7'h20);
        wt(1);
        cmp("dma halt", 1'b0, dmaHalt);
        wr(mmicr_pkg::OFF_STAT, 16'h8000);
        wt(1);
        cmp("dma halt", 1'b1, dmaHalt);
        rd(mmicr_pkg::OFF_EOI, 16'h0000);
        rd(8'h40, 16'h0000);
        final_report();
    end
endmodule : mmicr_regs_test
`default_nettype wire
